/* design/spd_pkg.sv */
// Constants and types for the strap pin latch and decoder
package spd_pkg;

	// ==========================================================
	// Strap pins
	localparam int STRAP_COUNT = 6;
	localparam int IN_ONLY_COUNT = 6;

	// Latched straps; bit 0 is the regulator-voltage strap
	typedef struct packed {
		logic sdio_edge_strap;
		logic log_and_timing_strap;
		logic spare_strap_pin;
		logic download_qualifier_strap;
		logic boot_select_strap;
		logic ldo_voltage_strap;
	} spd_strap_s;

	// Weak bias level of each strap while it is being sampled
	localparam spd_strap_s STRAP_BIAS_UP = 6'h32;

	// ==========================================================
	// Boot modes and decoded configuration
	typedef enum logic [1:0] {
		BOOT_FLASH = 2'b00,
		BOOT_DOWNLOAD = 2'b01,
		BOOT_UNDEFINED = 2'b10
	} spd_boot_e;

	typedef struct packed {
		spd_boot_e boot_mode;
		logic ldo_1v8;
		logic boot_log_en;
		logic sdio_in_rise;
		logic sdio_out_rise;
	} spd_cfg_s;

	typedef enum logic [0:0] {
		ST_SAMPLE = 1'b0,
		ST_RUN = 1'b1
	} spd_state_e;

	// ==========================================================
	// Register map
	localparam int ADDR_W = 12;
	localparam logic [11:0] REG_STRAP_STATUS = 12'h000;
	localparam logic [11:0] REG_OVERRIDE = 12'h004;

	// Override register fields
	localparam int OVR_LDO_EN = 0;
	localparam int OVR_LDO_1V8 = 1;
	localparam int OVR_SDIO_EN = 2;
	localparam int OVR_SDIO_IN_RISE = 3;
	localparam int OVR_SDIO_OUT_RISE = 4;
	localparam int OVR_BOOT_DONE = 5;
	localparam int OVR_W = 6;
	localparam logic [5:0] OVR_RESET = 6'h00;

endpackage

/* design/spd_strap_latch.sv */
// Strap pin sampling, latching, decoding and APB status and override
//
// Decided for this implementation: the register addresses and register access over APB.
`timescale 1ns/1ps
`default_nettype none

module spd_strap_latch
	import spd_pkg::*;
(
	// Clock and power-on reset
	input wire logic CLK_SYS,
	input wire logic RSTN,
	input wire logic CHIP_POWER_ENABLE,
	// APB slave
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [ADDR_W-1:0] PADDR,
	input wire logic [31:0] PWDATA,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	// Strap pads
	input wire logic [STRAP_COUNT-1:0] STRAP_PAD_IN,
	output logic [STRAP_COUNT-1:0] STRAP_PAD_OUT,
	output logic [STRAP_COUNT-1:0] STRAP_PAD_OE,
	output logic [STRAP_COUNT-1:0] STRAP_BIAS_EN,
	output logic [STRAP_COUNT-1:0] STRAP_BIAS_UP_SEL,
	// Normal function of the strap pads
	input wire logic [STRAP_COUNT-1:0] FUNC_OUT,
	input wire logic [STRAP_COUNT-1:0] FUNC_OE,
	output logic [STRAP_COUNT-1:0] FUNC_IN,
	// Input-only pads
	input wire logic [IN_ONLY_COUNT-1:0] IN_ONLY_OE_REQ,
	output logic [IN_ONLY_COUNT-1:0] IN_ONLY_PAD_OE,
	// Console transmit pin
	input wire logic BOOT_LOG_TX,
	input wire logic CONSOLE_FUNC_OUT,
	input wire logic CONSOLE_FUNC_OE,
	output logic CONSOLE_TX_OUT,
	output logic CONSOLE_TX_OE,
	// Decoded configuration
	output spd_cfg_s CFG,
	output logic CHIP_RUN
);

	// ==========================================================
	// Synchronisers
	logic [STRAP_COUNT-1:0] pad_meta;
	logic [STRAP_COUNT-1:0] pad_sync;
	logic ce_meta;
	logic ce_sync;

	always_ff @(posedge CLK_SYS or negedge RSTN) begin
		if (!RSTN) begin
			pad_meta <= STRAP_BIAS_UP;
			pad_sync <= STRAP_BIAS_UP;
			ce_meta <= 1'b0;
			ce_sync <= 1'b0;
		end else begin
			pad_meta <= STRAP_PAD_IN;
			pad_sync <= pad_meta;
			ce_meta <= CHIP_POWER_ENABLE;
			ce_sync <= ce_meta;
		end
	end

	// ==========================================================
	// Sample window and strap latches
	spd_state_e state;
	spd_state_e next_state;
	spd_strap_s strap;
	spd_strap_s next_strap;

	always_comb begin
		next_state = state;
		next_strap = strap;
		case (state)
			ST_SAMPLE: begin
				// Track the pads; the last value is kept at release
				next_strap = pad_sync;
				if (ce_sync) begin
					next_state = ST_RUN;
				end
			end
			ST_RUN: begin
				// Only a shutdown reopens the window
				if (!ce_sync) begin
					next_state = ST_SAMPLE;
				end
			end
			default: begin
				next_state = ST_SAMPLE;
			end
		endcase
	end

	always_ff @(posedge CLK_SYS or negedge RSTN) begin
		if (!RSTN) begin
			state <= ST_SAMPLE;
			strap <= STRAP_BIAS_UP;
		end else begin
			state <= next_state;
			strap <= next_strap;
		end
	end

	// ==========================================================
	// APB registers
	logic [OVR_W-1:0] ovr;
	logic [OVR_W-1:0] next_ovr;
	logic [31:0] next_prdata;
	logic err;
	logic next_err;
	logic setup;
	logic access;

	assign setup = PSEL && !PENABLE;
	assign access = PSEL && PENABLE;
	// Read data is fetched in setup so the access phase needs no wait
	assign PREADY = access;
	assign PSLVERR = access && err;

	always_comb begin
		next_prdata = PRDATA;
		next_err = err;
		next_ovr = ovr;
		if (setup) begin
			next_err = 1'b1;
			next_prdata = 32'h0000_0000;
			if (PADDR == REG_STRAP_STATUS) begin
				next_err = PWRITE;
				next_prdata = {{(32-STRAP_COUNT){1'b0}}, strap};
			end else if (PADDR == REG_OVERRIDE) begin
				next_err = 1'b0;
				next_prdata = {{(32-OVR_W){1'b0}}, ovr};
			end
		end
		if (access && PWRITE && PADDR == REG_OVERRIDE) begin
			next_ovr = PWDATA[OVR_W-1:0];
		end
		// Settings vanish with the chip when it is shut down
		if (state == ST_SAMPLE) begin
			next_ovr = OVR_RESET;
		end
	end

	always_ff @(posedge CLK_SYS or negedge RSTN) begin
		if (!RSTN) begin
			PRDATA <= 32'h0000_0000;
			err <= 1'b0;
			ovr <= OVR_RESET;
		end else begin
			PRDATA <= next_prdata;
			err <= next_err;
			ovr <= next_ovr;
		end
	end

	// ==========================================================
	// Decode and pad control
	spd_cfg_s next_cfg;
	logic boot_done;
	logic next_tx_out;
	logic next_tx_oe;
	logic [STRAP_COUNT-1:0] next_pad_out;
	logic [STRAP_COUNT-1:0] next_pad_oe;

	assign boot_done = ovr[OVR_BOOT_DONE];
	assign CHIP_RUN = (state == ST_RUN);
	assign STRAP_BIAS_EN = {STRAP_COUNT{state == ST_SAMPLE}};
	assign STRAP_BIAS_UP_SEL = STRAP_BIAS_UP;
	assign IN_ONLY_PAD_OE = IN_ONLY_OE_REQ & {IN_ONLY_COUNT{1'b0}};

	always_comb begin
		next_cfg.ldo_1v8 = strap.ldo_voltage_strap;
		if (ovr[OVR_LDO_EN]) begin
			next_cfg.ldo_1v8 = ovr[OVR_LDO_1V8];
		end
		if (strap.boot_select_strap) begin
			next_cfg.boot_mode = BOOT_FLASH;
		end else if (!strap.download_qualifier_strap) begin
			next_cfg.boot_mode = BOOT_DOWNLOAD;
		end else begin
			next_cfg.boot_mode = BOOT_UNDEFINED;
		end
		next_cfg.boot_log_en = strap.log_and_timing_strap;
		next_cfg.sdio_in_rise = strap.log_and_timing_strap;
		next_cfg.sdio_out_rise = strap.sdio_edge_strap;
		if (ovr[OVR_SDIO_EN]) begin
			next_cfg.sdio_in_rise = ovr[OVR_SDIO_IN_RISE];
			next_cfg.sdio_out_rise = ovr[OVR_SDIO_OUT_RISE];
		end
		// Pads stay quiet while sampled so nothing fights the bias
		next_pad_out = {STRAP_COUNT{1'b0}};
		next_pad_oe = {STRAP_COUNT{1'b0}};
		// Follow the next state so drive drops as the bias comes back
		if (next_state == ST_RUN) begin
			next_pad_out = FUNC_OUT;
			next_pad_oe = FUNC_OE;
		end
		// Boot phase lasts until firmware sets the boot-done bit
		next_tx_out = CONSOLE_FUNC_OUT;
		next_tx_oe = CONSOLE_FUNC_OE;
		if (state == ST_SAMPLE) begin
			next_tx_out = 1'b0;
			next_tx_oe = 1'b0;
		end else if (!boot_done) begin
			next_tx_out = BOOT_LOG_TX;
			next_tx_oe = strap.log_and_timing_strap;
		end
	end

	always_ff @(posedge CLK_SYS or negedge RSTN) begin
		if (!RSTN) begin
			CFG <= '0;
			STRAP_PAD_OUT <= {STRAP_COUNT{1'b0}};
			STRAP_PAD_OE <= {STRAP_COUNT{1'b0}};
			CONSOLE_TX_OUT <= 1'b0;
			CONSOLE_TX_OE <= 1'b0;
		end else begin
			CFG <= next_cfg;
			STRAP_PAD_OUT <= next_pad_out;
			STRAP_PAD_OE <= next_pad_oe;
			CONSOLE_TX_OUT <= next_tx_out;
			CONSOLE_TX_OE <= next_tx_oe;
		end
	end

	// Normal-function inputs are only meaningful once running
	assign FUNC_IN = pad_sync & {STRAP_COUNT{state == ST_RUN}};

	// ==========================================================
	// Assertions
	default clocking cb @(posedge CLK_SYS);
	endclocking
	default disable iff (!RSTN);

	a_capture_value: assert property (
		state == ST_SAMPLE && ce_sync |=> strap == $past(pad_sync))
		else $error("strap latch missed pad level at release");

	a_latch_hold: assert property (
		state == ST_RUN && $past(state) == ST_RUN |-> $stable(strap))
		else $error("strap latch changed while running");

	a_status_read: assert property (
		setup && PADDR == REG_STRAP_STATUS |=> PRDATA[5:0] == $past(strap))
		else $error("status read does not show latched straps");

	a_bias_window: assert property (
		STRAP_BIAS_EN != '0 |-> state == ST_SAMPLE && STRAP_PAD_OE == '0)
		else $error("bias engaged outside sampling");

	a_pad_return: assert property (
		state == ST_RUN && $past(state) == ST_RUN
		|-> STRAP_PAD_OE == $past(FUNC_OE))
		else $error("strap pad not back on normal function");

	a_ldo_decode: assert property (
		!ovr[OVR_LDO_EN] && $stable(strap) && $stable(ovr)
		|=> CFG.ldo_1v8 == $past(strap.ldo_voltage_strap))
		else $error("regulator voltage decode wrong");

	a_boot_decode: assert property (
		$stable(strap) ##1 strap.boot_select_strap
		|=> CFG.boot_mode == BOOT_FLASH)
		else $error("boot select decode wrong");

	a_boot_silent: assert property (
		state == ST_RUN && !boot_done && !strap.log_and_timing_strap
		|=> !CONSOLE_TX_OE)
		else $error("console driven during silent boot");

	a_sdio_decode: assert property (
		!ovr[OVR_SDIO_EN] && $stable(strap) && $stable(ovr)
		|=> CFG.sdio_in_rise == $past(strap.log_and_timing_strap)
		&& CFG.sdio_out_rise == $past(strap.sdio_edge_strap))
		else $error("SDIO edge decode wrong");

	a_override: assert property (
		ovr[OVR_LDO_EN] |=> CFG.ldo_1v8 == $past(ovr[OVR_LDO_1V8]))
		else $error("regulator override ignored");

	a_input_only: assert property (
		IN_ONLY_PAD_OE == '0)
		else $error("input-only pad driven");

	a_shutdown: assert property (
		!CHIP_POWER_ENABLE [*3] |=> state == ST_SAMPLE)
		else $error("chip kept running with enable low");

	c_release: cover property (state == ST_SAMPLE ##1 state == ST_RUN);
	c_download: cover property (CFG.boot_mode == BOOT_DOWNLOAD);
	c_override_write: cover property (access && PWRITE
		&& PADDR == REG_OVERRIDE);
	c_bad_addr: cover property (PSLVERR);

endmodule // spd_strap_latch

`default_nettype wire

/* verification/spd_strap_host.sv */
// Strap host model: pull resistors or host GPIOs on the strap pads
`timescale 1ns/1ps
`default_nettype none

module spd_strap_host (
	// Host drive and pad side
	input wire logic clk,
	input wire logic [5:0] drv_en,
	input wire logic [5:0] drv_val,
	input wire logic [5:0] pad_out,
	input wire logic [5:0] pad_oe,
	input wire logic [5:0] bias_en,
	input wire logic [5:0] bias_up,
	output logic [5:0] pad_in
);
	logic [5:0] last;

	always_ff @(posedge clk) begin
		last <= pad_in;
	end

	// A floating pad never repeats its old level, so no stale value passes
	always_comb begin
		for (int i = 0; i < 6; i++) begin
			if (pad_oe[i])
				pad_in[i] = pad_out[i];
			else if (drv_en[i])
				pad_in[i] = drv_val[i];
			else if (bias_en[i])
				pad_in[i] = bias_up[i];
			else
				pad_in[i] = ~last[i];
		end
	end
endmodule // spd_strap_host

`default_nettype wire

/* verification/strap_pin_latch_decoder_tb.sv */
// Self-checking bench for the strap latch and decoder
`timescale 1ns/1ps
`default_nettype none

module strap_pin_latch_decoder_tb import spd_pkg::*;;
	logic clk, rstn, en, psel, pen, pwr, pready, pslverr, e;
	logic blog, cfo, cfoe, ctx, ctxoe, run;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, r, o;
	logic [5:0] pin, pout, poe, ben, bup, fout, foe, fin, ireq, ioe;
	logic [5:0] den, dval;
	spd_strap_s s;
	spd_cfg_s cfg;
	int errors, checks, seed, cyc;
	logic [5:0] tbl [0:5] = '{6'h32, 6'h00, 6'h3F, 6'h10, 6'h20, 6'h04};

	spd_strap_latch spd_strap_latch_i (.CLK_SYS(clk), .RSTN(rstn),
		.CHIP_POWER_ENABLE(en), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr),
		.PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
		.PSLVERR(pslverr), .STRAP_PAD_IN(pin), .STRAP_PAD_OUT(pout),
		.STRAP_PAD_OE(poe), .STRAP_BIAS_EN(ben), .STRAP_BIAS_UP_SEL(bup),
		.FUNC_OUT(fout), .FUNC_OE(foe), .FUNC_IN(fin),
		.IN_ONLY_OE_REQ(ireq), .IN_ONLY_PAD_OE(ioe), .BOOT_LOG_TX(blog),
		.CONSOLE_FUNC_OUT(cfo), .CONSOLE_FUNC_OE(cfoe),
		.CONSOLE_TX_OUT(ctx), .CONSOLE_TX_OE(ctxoe), .CFG(cfg),
		.CHIP_RUN(run));

	spd_strap_host spd_strap_host_i (.clk(clk), .drv_en(den),
		.drv_val(dval), .pad_out(pout), .pad_oe(poe), .bias_en(ben),
		.bias_up(bup), .pad_in(pin));

	// ==========================================================
	// Helpers
	function automatic spd_cfg_s exp_cfg(spd_strap_s t, logic [5:0] v);
		spd_cfg_s c;
		c.boot_mode = t.boot_select_strap ? BOOT_FLASH :
			t.download_qualifier_strap ? BOOT_UNDEFINED : BOOT_DOWNLOAD;
		c.ldo_1v8 = v[OVR_LDO_EN] ? v[OVR_LDO_1V8] : t.ldo_voltage_strap;
		c.boot_log_en = t.log_and_timing_strap;
		c.sdio_in_rise = v[OVR_SDIO_EN] ? v[OVR_SDIO_IN_RISE] :
			t.log_and_timing_strap;
		c.sdio_out_rise = v[OVR_SDIO_EN] ? v[OVR_SDIO_OUT_RISE] :
			t.sdio_edge_strap;
		return c;
	endfunction

	task automatic chk(input logic [31:0] g, input logic [31:0] x);
		checks++;
		if (g !== x) begin
			errors++;
			$display("mismatch t=%0t got %h exp %h", $time, g, x);
		end
	endtask

	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pen <= 1'b0;
		pwr <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		pen <= 1'b1;
		do begin
			@(posedge clk);
		end while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		pen <= 1'b0;
	endtask

	task automatic test_done();
		$display("checks %0d errors %0d", checks, errors);
		if (errors == 0 && checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	// ==========================================================
	// Clock and hang guard
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			errors++;
			test_done();
		end
	end

	// ==========================================================
	// Power cycles over strap patterns
	initial begin
		seed = 62292;
		{rstn, en, psel, pen, pwr, paddr, pwdata} = '0;
		{fout, foe, ireq, blog, cfo, cfoe, den, dval} = '0;
		repeat (4) @(posedge clk);
		rstn <= 1'b1;
		for (int i = 0; i < 10; i++) begin
			s = (i < 6) ? tbl[i] : 6'($random(seed));
			@(posedge clk);
			en <= 1'b0;
			den <= (i == 0) ? 6'h00 : 6'h3F;
			dval <= s;
			{fout, foe, ireq, blog, cfo, cfoe} <= 21'($random(seed));
			repeat (4) @(posedge clk);
			chk(32'(ben), 32'h0000_003F);
			chk(32'(poe), 32'h0000_0000);
			chk(32'(run), 32'h0000_0000);
			chk(32'(fin), 32'h0000_0000);
			chk(32'(bup), 32'h0000_0032);
			en <= 1'b1;
			for (int n = 0; n < 20 && run !== 1'b1; n++)
				@(posedge clk);
			repeat (3) @(posedge clk);
			chk(32'(cfg), 32'(exp_cfg(s, 6'h00)));
			chk(32'(ben), 32'h0000_0000);
			chk(32'(poe), 32'(foe));
			chk(32'(ctxoe), 32'(s[4]));
			chk(32'(ioe), 32'h0000_0000);
			chk(32'(pout), 32'(fout));
			if (i > 0)
				chk(32'(fin), 32'((foe & fout) | (~foe & dval)));
			if (s[4])
				chk(32'(ctx), 32'(blog));
			apb(1'b0, REG_STRAP_STATUS, 32'h0000_0000);
			chk(r, 32'(s));
			apb(1'b1, REG_STRAP_STATUS, 32'hFFFF_FFFF);
			chk(32'(e), 32'h0000_0001);
			den <= 6'($random(seed));
			dval <= ~s;
			repeat (4) @(posedge clk);
			apb(1'b0, REG_STRAP_STATUS, 32'h0000_0000);
			chk(r, 32'(s));
			apb(1'b0, 12'hFFC, 32'h0000_0000);
			chk(32'(e), 32'h0000_0001);
			chk(r, 32'h0000_0000);
			o = $random(seed);
			apb(1'b1, REG_OVERRIDE, o);
			repeat (3) @(posedge clk);
			chk(32'(cfg), 32'(exp_cfg(s, o[5:0])));
			chk(32'(ctxoe), 32'(o[5] ? cfoe : s[4]));
			if (o[5] || s[4])
				chk(32'(ctx), 32'(o[5] ? cfo : blog));
			apb(1'b0, REG_OVERRIDE, 32'h0000_0000);
			chk(r, 32'(o[5:0]));
			$display("test %0d done", i);
		end
		test_done();
	end
endmodule // strap_pin_latch_decoder_tb

`default_nettype wire
